// ===== src/wdma_pkg.sv
// Constants, types and register map for the 48-bit DMA write engine.
// Assumes a single clock domain and a 32-bit classic Wishbone master.
package wdma_pkg;
	localparam logic [7:0] CMD_DMA_EXT = 8'h35;
	localparam logic [7:0] CMD_QUEUED = 8'h61;
	// Byte addresses of the one-word registers.
	localparam logic [7:0] A_DATA = 8'h00;
	localparam logic [7:0] A_FEAT = 8'h04;
	localparam logic [7:0] A_COUNT = 8'h08;
	localparam logic [7:0] A_LO = 8'h0C;
	localparam logic [7:0] A_MID = 8'h10;
	localparam logic [7:0] A_HI = 8'h14;
	localparam logic [7:0] A_DEV = 8'h18;
	localparam logic [7:0] A_CMD = 8'h1C;
	localparam logic [7:0] A_ERR = 8'h20;
	localparam logic [7:0] A_CTRL = 8'h24;
	// Status, error, device and control bit positions.
	localparam int S_BSY = 7;
	localparam int S_RDY = 6;
	localparam int S_DSC = 4;
	localparam int S_DRQ = 3;
	localparam int S_ERR = 0;
	localparam int E_CRC = 7;
	localparam int E_IDN = 4;
	localparam int E_ABT = 2;
	localparam logic [7:0] E_USED = 8'h94;
	localparam int DEV_FUA = 7;
	localparam int PRIO_BIT = 7;
	localparam int TAG_LSB = 3;
	localparam int CTRL_HOB = 7;
	localparam int CTRL_WCE = 0;
	localparam logic [16:0] ZERO_COUNT = 17'h1_0000;
	localparam logic [15:0] SECTOR_WORDS = 16'h0100;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_COMMIT = 2'b10
	} state_t;
	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} pair_t;
	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic [47:0] lba;
		logic [4:0] tag;
		logic prio;
	} media_t;
	typedef struct packed {
		state_t state;
		pair_t feat;
		pair_t count;
		pair_t lo;
		pair_t mid;
		pair_t hi;
		logic [7:0] dev;
		logic hob;
		logic wce;
		logic [7:0] err;
		logic errflag;
		logic intr;
		logic [16:0] remaining;
		logic [47:0] lba;
		logic [15:0] wcnt;
		logic fua;
		logic dmarq;
		logic flush;
		logic ack;
		logic [31:0] rdata;
		media_t mo;
	} regs_t;
endpackage

// ===== src/ext_dma_queued_write_cmds.sv
// Command engine for the 48-bit DMA write and the queued DMA write.
// Assumes a classic Wishbone master, a host DMA that writes the data
// register while dma_req is high, and media logic on the same clock.
`timescale 1ns/1ps
module ext_dma_queued_write_cmds #(
	parameter logic [15:0] SECTOR_WORDS = wdma_pkg::SECTOR_WORDS
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clock_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic dma_req,
	output logic intrq,
	output wdma_pkg::media_t media,
	input wire logic media_ready,
	input wire logic media_fail,
	input wire logic link_crc_err,
	output logic flush_req,
	input wire logic flush_done
);
	logic [1:0] rst_q;
	logic rst_n;
	wdma_pkg::regs_t r;
	wdma_pkg::regs_t n;
	logic req;
	logic wr;
	logic rd;
	logic cmd_wr;
	logic data_wr;
	logic fin;
	logic fail;
	logic [15:0] cnt16;
	logic [7:0] status;

	// Reset enters asynchronously but is released through two stages.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	always_comb begin
		n = r;
		n.ack = 1'b0;
		n.mo.valid = 1'b0;
		fin = 1'b0;
		fail = 1'b0;
		cnt16 = 16'h0000;
		req = wb_cyc_i && wb_stb_i && !r.ack;
		wr = req && wb_we_i && wb_sel_i[0];
		rd = req && !wb_we_i;
		cmd_wr = wr && wb_adr_i == wdma_pkg::A_CMD
			&& r.state == wdma_pkg::ST_IDLE;
		data_wr = wr && wb_adr_i == wdma_pkg::A_DATA && r.dmarq;
		status = 8'h00;
		status[wdma_pkg::S_BSY] = r.state != wdma_pkg::ST_IDLE;
		status[wdma_pkg::S_RDY] = 1'b1;
		status[wdma_pkg::S_DSC] = 1'b1;
		status[wdma_pkg::S_DRQ] = r.dmarq;
		status[wdma_pkg::S_ERR] = r.errflag;
		if (req) begin
			n.ack = 1'b1;
		end
		// Read path; the select bit picks current or previous bytes.
		if (rd) begin
			n.rdata = 32'h0000_0000;
			if (wb_adr_i == wdma_pkg::A_COUNT) begin
				n.rdata[7:0] = r.hob ? r.count.prev : r.count.cur;
			end else if (wb_adr_i == wdma_pkg::A_LO) begin
				n.rdata[7:0] = r.hob ? r.lo.prev : r.lo.cur;
			end else if (wb_adr_i == wdma_pkg::A_MID) begin
				n.rdata[7:0] = r.hob ? r.mid.prev : r.mid.cur;
			end else if (wb_adr_i == wdma_pkg::A_HI) begin
				n.rdata[7:0] = r.hob ? r.hi.prev : r.hi.cur;
			end else if (wb_adr_i == wdma_pkg::A_DEV) begin
				n.rdata[7:0] = r.dev;
			end else if (wb_adr_i == wdma_pkg::A_CMD) begin
				n.rdata[7:0] = status;
				n.intr = 1'b0;
			end else if (wb_adr_i == wdma_pkg::A_ERR) begin
				n.rdata[7:0] = r.err & wdma_pkg::E_USED;
			end else if (wb_adr_i == wdma_pkg::A_CTRL) begin
				n.rdata[wdma_pkg::CTRL_HOB] = r.hob;
				n.rdata[wdma_pkg::CTRL_WCE] = r.wce;
			end
		end
		// Task-file bytes are frozen while a command runs, so the
		// error address cannot be disturbed in the cycle it is loaded.
		if (wr && r.state == wdma_pkg::ST_IDLE) begin
			if (wb_adr_i == wdma_pkg::A_FEAT) begin
				n.feat = {r.feat.cur, wb_dat_i[7:0]};
			end else if (wb_adr_i == wdma_pkg::A_COUNT) begin
				n.count = {r.count.cur, wb_dat_i[7:0]};
			end else if (wb_adr_i == wdma_pkg::A_LO) begin
				n.lo = {r.lo.cur, wb_dat_i[7:0]};
			end else if (wb_adr_i == wdma_pkg::A_MID) begin
				n.mid = {r.mid.cur, wb_dat_i[7:0]};
			end else if (wb_adr_i == wdma_pkg::A_HI) begin
				n.hi = {r.hi.cur, wb_dat_i[7:0]};
			end else if (wb_adr_i == wdma_pkg::A_DEV) begin
				n.dev = wb_dat_i[7:0];
			end
		end
		if (wr && wb_adr_i == wdma_pkg::A_CTRL) begin
			n.hob = wb_dat_i[wdma_pkg::CTRL_HOB];
			n.wce = wb_dat_i[wdma_pkg::CTRL_WCE];
		end
		// Command decode.
		if (cmd_wr) begin
			n.err = 8'h00;
			n.errflag = 1'b0;
			n.intr = 1'b0;
			n.wcnt = 16'h0000;
			n.lba = {r.hi.prev, r.mid.prev, r.lo.prev,
				r.hi.cur, r.mid.cur, r.lo.cur};
			n.fua = 1'b0;
			n.mo.tag = 5'h00;
			n.mo.prio = 1'b0;
			if (wb_dat_i[7:0] == wdma_pkg::CMD_DMA_EXT) begin
				cnt16 = {r.count.prev, r.count.cur};
				n.state = wdma_pkg::ST_XFER;
			end else if (wb_dat_i[7:0] == wdma_pkg::CMD_QUEUED) begin
				cnt16 = {r.feat.prev, r.feat.cur};
				n.mo.tag = r.count.cur[7:wdma_pkg::TAG_LSB];
				n.mo.prio = r.count.prev[wdma_pkg::PRIO_BIT];
				n.fua = r.dev[wdma_pkg::DEV_FUA];
				n.state = wdma_pkg::ST_XFER;
			end else begin
				n.err[wdma_pkg::E_ABT] = 1'b1;
				n.errflag = 1'b1;
				n.intr = 1'b1;
			end
			n.remaining = cnt16 == 16'h0000 ? wdma_pkg::ZERO_COUNT
				: {1'b0, cnt16};
		end
		// Data phase: one 16-bit word per accepted data write.
		if (r.state == wdma_pkg::ST_XFER) begin
			if (media_fail || link_crc_err) begin
				fail = 1'b1;
				n.err[wdma_pkg::E_IDN] = media_fail;
				n.err[wdma_pkg::E_CRC] = link_crc_err;
			end else if (data_wr) begin
				n.mo.valid = 1'b1;
				n.mo.word = wb_dat_i[15:0];
				n.mo.lba = r.lba;
				n.wcnt = 16'(r.wcnt + 16'h0001);
				if (n.wcnt == SECTOR_WORDS) begin
					n.wcnt = 16'h0000;
					n.lba = 48'(r.lba + 48'h0000_0000_0001);
					n.remaining = 17'(r.remaining - 17'h0_0001);
					if (r.remaining == 17'h0_0001) begin
						n.state = wdma_pkg::ST_COMMIT;
					end
				end
			end
		end
		// Completion: forced or uncached writes wait for the commit.
		if (r.state == wdma_pkg::ST_COMMIT) begin
			if (media_fail) begin
				fail = 1'b1;
				n.err[wdma_pkg::E_IDN] = 1'b1;
			end else if (!r.flush) begin
				fin = 1'b1;
			end else if (flush_done) begin
				fin = 1'b1;
			end
		end
		if (fail) begin
			// Failing sector address replaces the task-file bytes.
			n.lo = {r.lba[31:24], r.lba[7:0]};
			n.mid = {r.lba[39:32], r.lba[15:8]};
			n.hi = {r.lba[47:40], r.lba[23:16]};
			n.errflag = 1'b1;
		end
		if (fin || fail) begin
			n.state = wdma_pkg::ST_IDLE;
			n.intr = 1'b1;
		end
		// The request drops one cycle after the media stalls, so the
		// media side must take one more word after media_ready falls.
		n.dmarq = n.state == wdma_pkg::ST_XFER && media_ready
			&& !fail && !cmd_wr;
		n.flush = n.state == wdma_pkg::ST_COMMIT
			&& (n.fua || !r.wce);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else if (clock_en) begin
			r <= n;
		end
	end

	assign wb_dat_o = r.rdata;
	assign wb_ack_o = r.ack;
	assign dma_req = r.dmarq;
	assign intrq = r.intr;
	assign media = r.mo;
	assign flush_req = r.flush;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	start_ext_a: assert property (clock_en && cmd_wr
		&& wb_dat_i[7:0] == wdma_pkg::CMD_DMA_EXT |=>
		r.state == wdma_pkg::ST_XFER
		&& r.remaining[15:0] == $past({r.count.prev, r.count.cur}))
		else $error("extended write start or count wrong");
	start_q_a: assert property (clock_en && cmd_wr
		&& wb_dat_i[7:0] == wdma_pkg::CMD_QUEUED |=>
		r.state == wdma_pkg::ST_XFER
		&& r.mo.tag == $past(r.count.cur[7:3])
		&& r.remaining[15:0] == $past({r.feat.prev, r.feat.cur}))
		else $error("queued write start, tag or count wrong");
	zero_count_a: assert property (clock_en && cmd_wr
		&& wb_dat_i[7:0] == wdma_pkg::CMD_DMA_EXT
		&& r.count == 16'h0000 |=> r.remaining == 17'h1_0000)
		else $error("zero count not taken as full range");
	word_gate_a: assert property (r.mo.valid |->
		$past(r.dmarq) && $past(wb_dat_i[15:0]) == r.mo.word)
		else $error("word moved without request");
	one_irq_a: assert property ($rose(r.intr) |->
		r.state == wdma_pkg::ST_IDLE && !r.dmarq)
		else $error("interrupt before status was valid");
	fail_stop_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER && media_fail |=>
		r.state == wdma_pkg::ST_IDLE && !r.dmarq ##1 !r.mo.valid)
		else $error("write went on after failing sector");
	err_addr_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER && media_fail |=>
		r.lo.cur == $past(r.lba[7:0])
		&& r.hi.prev == $past(r.lba[47:40]) && r.errflag)
		else $error("failing address not left in registers");
	fua_wait_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_COMMIT && r.fua
		&& !flush_done && !media_fail |=>
		r.state == wdma_pkg::ST_COMMIT && !r.intr)
		else $error("forced write completed before commit");
	err_bits_a: assert property ((r.err & ~wdma_pkg::E_USED) == 8'h00
		&& (r.rdata[7:0] & ~wdma_pkg::E_USED) == 8'h00
		|| !$past(rd && wb_adr_i == wdma_pkg::A_ERR))
		else $error("unused error bit set");
	busy_stat_a: assert property (clock_en && rd
		&& wb_adr_i == wdma_pkg::A_CMD && r.state == wdma_pkg::ST_IDLE
		|=> r.rdata[7:5] == 3'b010 && r.rdata[2] == 1'b0)
		else $error("ending status bits wrong");
	stable_a: assert property (r.state == wdma_pkg::ST_IDLE
		&& !(clock_en && wr) |=> $stable(r.lo) && $stable(r.hi))
		else $error("error address changed while idle");

	// Data phase checks.
	word_width_a: assert property (clock_en && data_wr
		&& r.state == wdma_pkg::ST_XFER && !media_fail && !link_crc_err
		|=> r.mo.valid && r.mo.word == $past(wb_dat_i[15:0]))
		else $error("accepted data word not passed on");
	drop_word_a: assert property (clock_en && wr
		&& wb_adr_i == wdma_pkg::A_DATA && !r.dmarq |=> !r.mo.valid)
		else $error("data word taken without request");
	req_state_a: assert property (r.dmarq |->
		r.state == wdma_pkg::ST_XFER)
		else $error("request raised outside the data phase");
	ready_gate_a: assert property (clock_en && !media_ready
		&& r.state == wdma_pkg::ST_XFER |=> !r.dmarq)
		else $error("request stayed up while media stalled");
	ack_once_a: assert property (clock_en && r.ack |=> !r.ack)
		else $error("bus acknowledge stood two cycles");

	// Command start checks.
	lba_load_a: assert property (clock_en && cmd_wr |=>
		r.lba == $past({r.hi.prev, r.mid.prev, r.lo.prev,
		r.hi.cur, r.mid.cur, r.lo.cur}))
		else $error("start address not assembled from six bytes");
	prio_load_a: assert property (clock_en && cmd_wr
		&& wb_dat_i[7:0] == wdma_pkg::CMD_QUEUED |=>
		r.mo.prio == $past(r.count.prev[wdma_pkg::PRIO_BIT]))
		else $error("queued priority not taken");
	fua_load_a: assert property (clock_en && cmd_wr |=>
		r.fua == ($past(wb_dat_i[7:0]) == wdma_pkg::CMD_QUEUED
		&& $past(r.dev[wdma_pkg::DEV_FUA])))
		else $error("forced access bit taken wrongly");
	tag_hold_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER |=>
		$stable(r.mo.tag) && $stable(r.mo.prio))
		else $error("tag or priority changed mid command");
	abort_a: assert property (clock_en && cmd_wr
		&& wb_dat_i[7:0] != wdma_pkg::CMD_DMA_EXT
		&& wb_dat_i[7:0] != wdma_pkg::CMD_QUEUED |=>
		r.state == wdma_pkg::ST_IDLE && r.err[wdma_pkg::E_ABT]
		&& r.errflag && r.intr)
		else $error("unknown command not aborted");

	// Progress and completion checks.
	sector_step_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER |=> r.lba == $past(r.lba)
		|| r.lba == $past(r.lba) + 48'h0000_0000_0001)
		else $error("sector address jumped");
	count_dec_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER |=>
		r.remaining == $past(r.remaining)
		|| r.remaining == $past(r.remaining) - 17'h0_0001)
		else $error("sector count moved by more than one");
	commit_entry_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER |=>
		r.state != wdma_pkg::ST_COMMIT
		|| $past(r.remaining) == 17'h0_0001)
		else $error("commit entered before the last sector");
	cache_done_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_COMMIT && !r.flush && !media_fail
		|=> r.state == wdma_pkg::ST_IDLE && r.intr)
		else $error("cached write did not complete");
	flush_state_a: assert property (r.flush |->
		r.state == wdma_pkg::ST_COMMIT)
		else $error("commit request outside commit phase");
	idle_quiet_a: assert property (r.state == wdma_pkg::ST_IDLE
		|-> !r.dmarq && !r.flush)
		else $error("request left up while idle");
	crc_bit_a: assert property (clock_en
		&& r.state == wdma_pkg::ST_XFER && link_crc_err && !media_fail
		|=> r.err[wdma_pkg::E_CRC] && !r.err[wdma_pkg::E_IDN]
		&& r.errflag && r.state == wdma_pkg::ST_IDLE)
		else $error("link error not reported as CRC");
	busy_write_a: assert property (clock_en && wr
		&& r.state != wdma_pkg::ST_IDLE && wb_adr_i == wdma_pkg::A_LO
		&& !media_fail && !link_crc_err |=> $stable(r.lo))
		else $error("address byte written while busy");

	// Status and interrupt checks.
	irq_clear_a: assert property (clock_en && rd
		&& wb_adr_i == wdma_pkg::A_CMD && !fin && !fail |=> !r.intr)
		else $error("status read did not clear interrupt");
	status_busy_a: assert property (clock_en && rd
		&& wb_adr_i == wdma_pkg::A_CMD |=>
		r.rdata[wdma_pkg::S_BSY] == $past(r.state != wdma_pkg::ST_IDLE))
		else $error("busy bit does not follow the engine");
	freeze_a: assert property (!clock_en |=> $stable(r))
		else $error("state moved while clock enable low");

	ext_done_c: cover property (r.state == wdma_pkg::ST_COMMIT
		&& !r.fua ##1 $rose(r.intr));
	fua_done_c: cover property (r.flush ##1 flush_done ##1 r.intr);
	fail_c: cover property (r.state == wdma_pkg::ST_XFER
		&& media_fail ##1 r.errflag);
	stall_c: cover property (r.dmarq ##1 !r.dmarq
		&& r.state == wdma_pkg::ST_XFER);
	cache_done_c: cover property (r.state == wdma_pkg::ST_COMMIT
		&& !r.flush ##1 r.intr);
endmodule

// ===== testbench/media_model.sv
// Model of the media back end that takes words and commits on request.
// Assumes the engine's clock and the package's media_t carrier.
`timescale 1ns/1ps
module media_model (
	input wire logic clock,
	input wire logic resetn,
	input wire wdma_pkg::media_t media,
	input wire logic flush_req,
	input wire logic slow,
	input wire logic fail_en,
	input wire logic [47:0] fail_lba,
	output logic media_ready,
	output logic media_fail,
	output logic flush_done,
	output int words,
	output int commits,
	output logic [47:0] last_lba,
	output logic [15:0] last_word
);
	int delay;
	logic [2:0] phase;
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			media_ready <= 1'b0;
			media_fail <= 1'b0;
			flush_done <= 1'b0;
			delay <= 0;
			phase <= 3'h0;
			words <= 0;
			commits <= 0;
		end else begin
			// A slow back end stalls two cycles in eight, so the request
			// sometimes falls just as the host answers it.
			phase <= phase + 3'h1;
			media_ready <= !slow || phase[2:1] != 2'b11;
			// The bad sector is reported one cycle after its first word arrives.
			media_fail <= fail_en && media.valid && media.lba == fail_lba;
			if (media.valid) begin
				words <= words + 1;
				last_lba <= media.lba;
				last_word <= media.word;
			end
			// Commit takes a few cycles, so early completion would show.
			delay <= flush_req ? delay + 1 : 0;
			flush_done <= flush_req && delay >= 5;
			if (flush_req && delay == 5)
				commits <= commits + 1;
		end
	end
endmodule

// ===== testbench/ext_dma_queued_write_cmds_tb.sv
// Bench for the DMA write engine: a table of commands, then odd cases.
// Assumes the package, the engine and media_model are compiled first.
`timescale 1ns/1ps
module ext_dma_queued_write_cmds_tb;
	localparam logic [15:0] SW = 16'h0004;
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] cnt;
		logic [15:0] feat;
		logic [47:0] lba;
		logic [7:0] dev;
		logic slow;
		logic [16:0] nsec;
		logic [7:0] err;
	} row_t;
	row_t rows [8] = '{
		'{8'h35, 16'h0002, 16'h0007, 48'h0605_0403_0201, 8'h40, 1'b0,
			17'h0_0002, 8'h00},
		'{8'h35, 16'h0101, 16'h0000, 48'hFFFF_FFFF_FF00, 8'hE0, 1'b1,
			17'h0_0101, 8'h00},
		'{8'h61, 16'h2880, 16'h0003, 48'h0000_0000_1000, 8'hC0, 1'b0,
			17'h0_0003, 8'h00},
		'{8'h61, 16'h8018, 16'h0001, 48'h0123_4567_89AB, 8'h40, 1'b1,
			17'h0_0001, 8'h00},
		'{8'h20, 16'h0001, 16'h0000, 48'h0000_0000_0000, 8'h40, 1'b0,
			17'h0_0000, 8'h04},
		'{8'h35, 16'h0000, 16'h0000, 48'h0000_0000_0200, 8'h40, 1'b0,
			17'h1_0000, 8'h10},
		'{8'h35, 16'h0002, 16'h0000, 48'h0000_0000_3000, 8'h40, 1'b0,
			17'h0_0002, 8'h80},
		'{8'h35, 16'h0003, 16'h0000, 48'h0A0B_0C0D_0E10, 8'h40, 1'b0,
			17'h0_0003, 8'h10}};
	logic clock, resetn, cyc, stb, we, ack, dreq, intrq;
	logic mready, mfail, fdone, freq, slow, fail_en;
	logic crc, cen, took, wce_on;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, rd;
	logic [47:0] fail_lba, last_lba;
	logic [15:0] last_word;
	wdma_pkg::media_t media;
	int n_fail, n_checks, words, commits;
	ext_dma_queued_write_cmds #(.SECTOR_WORDS(SW)) uut (
		.clock(clock), .resetn(resetn), .clock_en(cen), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dma_req(dreq),
		.intrq(intrq), .media(media), .media_ready(mready),
		.media_fail(mfail), .link_crc_err(crc), .flush_req(freq),
		.flush_done(fdone));
	media_model far (
		.clock(clock), .resetn(resetn), .media(media), .flush_req(freq),
		.slow(slow), .fail_en(fail_en), .fail_lba(fail_lba),
		.media_ready(mready), .media_fail(mfail), .flush_done(fdone),
		.words(words), .commits(commits), .last_lba(last_lba),
		.last_word(last_word));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic end_of_test;
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; returns just after one.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// The first edge is the one at which the engine takes the request.
		do begin
			@(posedge clock);
			t++;
			if (t == 1)
				took = dreq;
		end while (ack !== 1'b1 && t < 50);
		if (ack !== 1'b1)
			n_fail++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic run(input row_t r);
		int w0, c0, t, nw;
		logic [15:0] pairs [5];
		w0 = words;
		c0 = commits;
		fail_en <= (r.err == 8'h10);
		fail_lba <= r.lba + 48'h1;
		slow <= r.slow;
		pairs = '{r.feat, r.cnt, {r.lba[31:24], r.lba[7:0]},
			{r.lba[39:32], r.lba[15:8]}, {r.lba[47:40], r.lba[23:16]}};
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, wdma_pkg::A_FEAT + 8'(4 * i), {24'h0, pairs[i][15:8]});
			wb(1'b1, wdma_pkg::A_FEAT + 8'(4 * i), {24'h0, pairs[i][7:0]});
		end
		wb(1'b1, wdma_pkg::A_DEV, {24'h0, r.dev});
		wb(1'b1, wdma_pkg::A_CMD, {24'h0, r.cmd});
		if (r.cmd == 8'h61) begin
			chk(48'(media.tag), 48'(r.cnt[7:3]));
			chk(48'(media.prio), 48'(r.cnt[15]));
		end
		// A word sent as the request fell is dropped, so it is sent again.
		nw = 0;
		while (nw < int'(r.nsec) * int'(SW) && intrq !== 1'b1) begin
			t = 0;
			do begin
				@(posedge clock);
				t++;
			end while (dreq !== 1'b1 && intrq !== 1'b1 && t < 400);
			if (intrq !== 1'b1) begin
				wb(1'b1, wdma_pkg::A_DATA, 32'(nw));
				if (took)
					nw++;
				if (took && nw == 1 && r.err == 8'h80) begin
					crc <= 1'b1;
					@(posedge clock);
					crc <= 1'b0;
				end
			end
		end
		t = 0;
		while (intrq !== 1'b1 && t < 400) begin
			@(posedge clock);
			t++;
		end
		chk(48'(intrq), 48'h1);
		if (r.err == 8'h10)
			chk(48'(words - w0), 48'(SW) + 48'h1);
		if (r.err == 8'h00) begin
			chk(48'(words - w0), 48'(r.nsec) * 48'(SW));
			chk(last_lba, r.lba + 48'(r.nsec) - 48'h1);
			chk(48'(last_word), 48'(int'(r.nsec) * int'(SW) - 1));
			chk(48'(commits - c0), 48'(!(wce_on
				&& !(r.cmd == 8'h61 && r.dev[7]))));
		end
		wb(1'b0, wdma_pkg::A_CMD, 32'h0);
		chk(48'(rd), (r.err == 8'h00) ? 48'h50 : 48'h51);
		wb(1'b0, wdma_pkg::A_ERR, 32'h0);
		chk(48'(rd), 48'(r.err));
		chk(48'(intrq), 48'h0);
	endtask
	initial begin
		resetn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		slow = 1'b0;
		fail_en = 1'b0;
		fail_lba = 48'h0;
		crc = 1'b0;
		cen = 1'b1;
		took = 1'b0;
		wce_on = 1'b0;
		n_fail = 0;
		n_checks = 0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		chk(48'({dreq, intrq}), 48'h0);
		foreach (rows[k])
			run(rows[k]);
		chk(last_lba, 48'h0A0B_0C0D_0E11);
		// Failing address by byte select, current bytes then previous bytes.
		for (int h = 0; h < 2; h++) begin
			wb(1'b1, wdma_pkg::A_CTRL, 32'(h) << 7);
			for (int i = 0; i < 3; i++) begin
				wb(1'b0, wdma_pkg::A_LO + 8'(4 * i), 32'h0);
				chk(48'(rd), 48'(8'(48'h0A0B_0C0D_0E11 >> (8 * i + 24 * h))));
			end
		end
		// Cached writes: only the forced queued write waits for commit.
		wce_on = 1'b1;
		wb(1'b1, wdma_pkg::A_CTRL, 32'h0000_0001);
		run(rows[0]);
		run(rows[2]);
		// A frozen engine holds the bus request unanswered.
		fork
			wb(1'b1, wdma_pkg::A_CTRL, 32'h0000_0080);
			begin
				cen <= 1'b0;
				repeat (4) @(posedge clock);
				chk(48'(ack), 48'h0);
				cen <= 1'b1;
			end
		join
		wb(1'b0, wdma_pkg::A_CTRL, 32'h0);
		chk(48'(rd), 48'h80);
		wb(1'b1, 8'h40, 32'h0000_00FF);
		wb(1'b0, 8'h40, 32'h0);
		chk(48'(rd), 48'h0);
		// Reset in mid run clears a pending interrupt and the select.
		wb(1'b1, wdma_pkg::A_CMD, 32'h0000_0020);
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		chk(48'({dreq, intrq}), 48'h0);
		wb(1'b0, wdma_pkg::A_CTRL, 32'h0);
		chk(48'(rd), 48'h0);
		end_of_test();
	end
	initial begin
		#400_000;
		n_fail++;
		end_of_test();
	end
endmodule
